// ===== common/cifd_pkg.sv
package cifd_pkg;
  localparam int CIFD_HALF_W = 16;
  localparam int CIFD_NATIVE_W = 32;
  localparam int CIFD_REG_W = 3;
  localparam logic [3:0] CIFD_REGOFS_TOP = 4'h5;
  localparam int CIFD_REGOFS_BIT9 = 9;
  localparam int CIFD_REGOFS_LOAD_BIT = 11;
  localparam int CIFD_REGOFS_BYTE_BIT = 10;
  localparam logic [2:0] CIFD_IMMOFS_TOP = 3'h3;
  localparam int CIFD_IMMOFS_BYTE_BIT = 12;
  localparam int CIFD_IMMOFS_LOAD_BIT = 11;
  localparam int CIFD_IMM5_LSB = 6;
  localparam logic [7:0] CIFD_SPADJ_TOP = 8'hB0;
  localparam int CIFD_SPADJ_SIGN_BIT = 7;
  localparam logic [3:0] CIFD_LBL_TOP = 4'hF;
  localparam int CIFD_LBL_HALF_BIT = 11;
  localparam int CIFD_OFFSET_LSB = 3;
  localparam int CIFD_BASE_LSB = 3;
  localparam int CIFD_DEST_LSB = 0;
  localparam int CIFD_OFSREG_LSB = 6;
  typedef enum logic [2:0] {
    CIFD_FMT_NONE,
    CIFD_FMT_REG_OFS,
    CIFD_FMT_IMM_OFS,
    CIFD_FMT_SP_ADJ,
    CIFD_FMT_LONG_BL
  } cifd_format_type;
endpackage

// ===== hw/cifd_expand.sv
`timescale 1ns/1ps
`default_nettype none
module cifd_expand
  import cifd_pkg::*;
(
  input wire logic [15:0] half,
  input wire cifd_format_type fmt,
  output logic [31:0] native
);
  // minimal native image: fixed opcode skeletons with fields dropped in
  always_comb begin
    native = 32'h00000000;
    case (fmt)
      CIFD_FMT_REG_OFS: begin
        native = {4'hE, 3'h3, 1'h1, 1'h0, half[CIFD_REGOFS_BYTE_BIT], 1'h0,
                  half[CIFD_REGOFS_LOAD_BIT], 1'h0, half[5:3], 1'h0, half[2:0],
                  9'h000, half[8:6]};
      end
      CIFD_FMT_IMM_OFS: begin
        native = {4'hE, 3'h2, 1'h1, 1'h1, half[CIFD_IMMOFS_BYTE_BIT], 1'h0,
                  half[CIFD_IMMOFS_LOAD_BIT], 1'h0, half[5:3], 1'h0, half[2:0],
                  5'h00, half[10:6], 2'h0};
      end
      CIFD_FMT_SP_ADJ: begin
        native = {4'hE, 3'h1, half[CIFD_SPADJ_SIGN_BIT] ? 4'h2 : 4'h4,
                  1'h0, 4'hD, 4'hD, 4'hF, 1'h0, half[6:0]};
      end
      CIFD_FMT_LONG_BL: begin
        native = {4'hE, 3'h5, 1'h1, 12'h000, half[CIFD_LBL_HALF_BIT], half[10:0]};
      end
      default: begin
        native = 32'h00000000;
      end
    endcase
  end
endmodule // cifd_expand
`default_nettype wire

// ===== hw/cifd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module cifd_decoder
  import cifd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic half_valid,
  input wire logic [15:0] half_word,
  output logic out_valid,
  output cifd_format_type out_format,
  output logic out_load,
  output logic out_byte,
  output logic out_sp_negative,
  output logic out_second_half,
  output logic [2:0] offset_register_field,
  output logic [2:0] base_register_field,
  output logic [2:0] dest_register_field,
  output logic [4:0] five_bit_immediate_field,
  output logic [6:0] stack_adjust_magnitude,
  output logic [10:0] branch_offset_field,
  output logic [31:0] native_word
);
  // one match test per class, so priority lives only in classify
  function automatic logic is_reg_ofs(input logic [15:0] h);
    return (h[15:12] == CIFD_REGOFS_TOP) && !h[CIFD_REGOFS_BIT9];
  endfunction

  function automatic logic is_imm_ofs(input logic [15:0] h);
    return h[15:13] == CIFD_IMMOFS_TOP;
  endfunction

  // whole top byte compared: other codes share its upper nibble
  function automatic logic is_sp_adj(input logic [15:0] h);
    return h[15:8] == CIFD_SPADJ_TOP;
  endfunction

  function automatic logic is_long_bl(input logic [15:0] h);
    return h[15:12] == CIFD_LBL_TOP;
  endfunction

  function automatic cifd_format_type classify(input logic [15:0] h);
    cifd_format_type f;
    f = CIFD_FMT_NONE;
    if (is_reg_ofs(h)) begin
      f = CIFD_FMT_REG_OFS;
    end else if (is_imm_ofs(h)) begin
      f = CIFD_FMT_IMM_OFS;
    end else if (is_sp_adj(h)) begin
      f = CIFD_FMT_SP_ADJ;
    end else if (is_long_bl(h)) begin
      f = CIFD_FMT_LONG_BL;
    end
    return f;
  endfunction

  // base and dest sit at the same place in both load/store classes
  function automatic logic [2:0] base_of(input logic [15:0] h);
    return h[CIFD_BASE_LSB +: CIFD_REG_W];
  endfunction

  function automatic logic [2:0] dest_of(input logic [15:0] h);
    return h[CIFD_DEST_LSB +: CIFD_REG_W];
  endfunction

  function automatic logic [2:0] ofsreg_of(input logic [15:0] h);
    return h[CIFD_OFSREG_LSB +: CIFD_REG_W];
  endfunction

  function automatic logic [4:0] imm5_of(input logic [15:0] h);
    return h[CIFD_IMM5_LSB +: 5];
  endfunction

  function automatic logic [6:0] mag_of(input logic [15:0] h);
    return h[6:0];
  endfunction

  function automatic logic [10:0] branch_of(input logic [15:0] h);
    return h[10:0];
  endfunction

  cifd_format_type in_fmt;
  logic [31:0] in_native;
  // handshake group
  logic next_valid;
  cifd_format_type next_format;
  // field group
  logic next_load;
  logic next_byte;
  logic next_neg;
  logic next_second;
  logic [2:0] next_ofs;
  logic [2:0] next_base;
  logic [2:0] next_dest;
  logic [4:0] next_imm;
  logic [6:0] next_mag;
  logic [10:0] next_br;
  // expansion group
  logic [31:0] next_native;

  assign in_fmt = classify(half_word);

  cifd_expand u_expand (
    .half(half_word),
    .fmt(in_fmt),
    .native(in_native)
  );

  // no ready: every offered halfword is taken at the edge
  always_comb begin
    next_valid = half_valid;
    next_format = CIFD_FMT_NONE;
    if (half_valid) begin
      next_format = in_fmt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_format <= CIFD_FMT_NONE;
    end else begin
      out_valid <= next_valid;
      out_format <= next_format;
    end
  end

  // a field is zero outside its own class, so nothing stale leaks onward
  always_comb begin
    next_load = 1'b0;
    next_byte = 1'b0;
    next_neg = 1'b0;
    next_second = 1'b0;
    next_ofs = 3'h0;
    next_base = 3'h0;
    next_dest = 3'h0;
    next_imm = 5'h00;
    next_mag = 7'h00;
    next_br = 11'h000;
    if (half_valid) begin
      case (in_fmt)
        CIFD_FMT_REG_OFS: begin
          next_load = half_word[CIFD_REGOFS_LOAD_BIT];
          next_byte = half_word[CIFD_REGOFS_BYTE_BIT];
          next_ofs = ofsreg_of(half_word);
          next_base = base_of(half_word);
          next_dest = dest_of(half_word);
        end
        CIFD_FMT_IMM_OFS: begin
          next_load = half_word[CIFD_IMMOFS_LOAD_BIT];
          next_byte = half_word[CIFD_IMMOFS_BYTE_BIT];
          next_imm = imm5_of(half_word);
          next_base = base_of(half_word);
          next_dest = dest_of(half_word);
        end
        CIFD_FMT_SP_ADJ: begin
          next_neg = half_word[CIFD_SPADJ_SIGN_BIT];
          next_mag = mag_of(half_word);
        end
        CIFD_FMT_LONG_BL: begin
          // halves are not paired here or in the native stage; each half expands alone
          next_second = half_word[CIFD_LBL_HALF_BIT];
          next_br = branch_of(half_word);
        end
        default: begin
          // unlisted formats pass with class none and empty fields
          next_load = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      out_load <= 1'b0;
      out_byte <= 1'b0;
      out_sp_negative <= 1'b0;
      out_second_half <= 1'b0;
      offset_register_field <= 3'h0;
      base_register_field <= 3'h0;
      dest_register_field <= 3'h0;
      five_bit_immediate_field <= 5'h00;
      stack_adjust_magnitude <= 7'h00;
      branch_offset_field <= 11'h000;
    end else begin
      out_load <= next_load;
      out_byte <= next_byte;
      out_sp_negative <= next_neg;
      out_second_half <= next_second;
      offset_register_field <= next_ofs;
      base_register_field <= next_base;
      dest_register_field <= next_dest;
      five_bit_immediate_field <= next_imm;
      stack_adjust_magnitude <= next_mag;
      branch_offset_field <= next_br;
    end
  end

  // native word is zero for idle cycles and unlisted formats
  always_comb begin
    next_native = 32'h00000000;
    if (half_valid) begin
      next_native = in_native;
    end
  end

  // one register stage so every output is a flop; latency fixed at one edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      native_word <= 32'h00000000;
    end else begin
      native_word <= next_native;
    end
  end
endmodule // cifd_decoder
`default_nettype wire

// ===== verif/cifd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module cifd_fetch_model (
  input wire logic sys_clk,
  input wire logic req,
  input wire logic [15:0] word,
  output logic half_valid,
  output logic [15:0] half_word
);
  logic [15:0] last = 16'hA5A5;
  // idle bus toggles so a stale word never passes
  always @(posedge sys_clk) last <= half_word;
  assign half_valid = req;
  assign half_word = req ? word : ~last;
endmodule // cifd_fetch_model
`default_nettype wire

// ===== verif/cifd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cifd_checker
  import cifd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic half_valid,
  input wire logic [15:0] half_word,
  input wire logic out_valid,
  input wire cifd_format_type out_format,
  input wire logic out_load,
  input wire logic out_byte,
  input wire logic out_sp_negative,
  input wire logic out_second_half,
  input wire logic [2:0] offset_register_field,
  input wire logic [2:0] base_register_field,
  input wire logic [2:0] dest_register_field,
  input wire logic [4:0] five_bit_immediate_field,
  input wire logic [6:0] stack_adjust_magnitude,
  input wire logic [10:0] branch_offset_field,
  input wire logic [31:0] native_word
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_valid_follows: assert property (half_valid |=> out_valid) else $error("lost");
  a_valid_drops: assert property (!half_valid |=> !out_valid) else $error("extra");
  a_idle_quiet: assert property (!out_valid |-> out_format == CIFD_FMT_NONE)
    else $error("idle");
  a_known_expands: assert property (out_format != CIFD_FMT_NONE
    |-> native_word != 32'h0)
    else $error("native");
  a_signed_half_none: assert property (half_valid && half_word[15:12] == 4'h5
    && half_word[9]
    |=> out_format == CIFD_FMT_NONE && native_word == 32'h0) else $error("none");
  a_reg_ofs: assert property (half_valid && half_word[15:12] == 4'h5
    && !half_word[9]
    |=> out_format == CIFD_FMT_REG_OFS && {out_load, out_byte, offset_register_field,
    base_register_field, dest_register_field} == {$past(half_word[11:10]), $past(half_word[8:0])})
    else $error("reg");
  a_imm_ofs: assert property (half_valid && half_word[15:13] == 3'h3
    |=> out_format == CIFD_FMT_IMM_OFS && {out_byte, out_load, five_bit_immediate_field,
    base_register_field, dest_register_field} == $past(half_word[12:0])) else $error("imm");
  a_sp_adjust: assert property (half_valid && half_word[15:8] == 8'hB0
    |=> out_format == CIFD_FMT_SP_ADJ
    && {out_sp_negative, stack_adjust_magnitude} == $past(half_word[7:0])) else $error("sp");
  a_long_branch: assert property (half_valid && half_word[15:12] == 4'hF
    |=> out_format == CIFD_FMT_LONG_BL
    && {out_second_half, branch_offset_field} == $past(half_word[11:0])) else $error("bl");
endmodule // cifd_checker
bind cifd_decoder cifd_checker cifd_checker_i (.*);
`default_nettype wire

// ===== verif/compact_instruction_format_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module compact_instruction_format_decoder_tb_top
  import cifd_pkg::*;
;
  logic sys_clk = 0, nrst = 0, req = 0, half_valid, out_valid, out_load, out_byte;
  logic out_sp_negative, out_second_half;
  logic [15:0] word = 16'h0, half_word;
  cifd_format_type out_format;
  logic [2:0] offset_register_field, base_register_field, dest_register_field;
  logic [4:0] five_bit_immediate_field;
  logic [6:0] stack_adjust_magnitude;
  logic [10:0] branch_offset_field;
  logic [31:0] native_word;
  int failures = 0, checks = 0;
  always #20 sys_clk = ~sys_clk;
  cifd_fetch_model cifd_fetch_model_i (.*);
  cifd_decoder cifd_decoder_i (.*);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task put(input logic [15:0] w, input logic idle);
    req = !idle;
    word = w;
    @(posedge sys_clk);
    #1;
    chk("valid", 32'(!idle), 32'(out_valid));
  endtask
  task t_reg_ofs();
    for (int i = 0; i < 4; i++) begin
      put({4'h5, 2'(i), 1'b0, 3'(i), 3'(i + 3), 3'(7 - i)}, 0);
      chk("reg", 32'({CIFD_FMT_REG_OFS, 2'(i), 3'(i), 3'(i + 3), 3'(7 - i)}),
        32'({out_format, out_load, out_byte, offset_register_field, base_register_field,
        dest_register_field}));
    end
  endtask
  task t_imm_ofs();
    for (int i = 0; i < 4; i++) begin
      put({3'h3, 2'(i), 5'(i * 10 + 1), 3'(i), 3'(~i)}, 0);
      chk("imm", 32'({CIFD_FMT_IMM_OFS, 2'(i), 5'(i * 10 + 1), 3'(i), 3'(~i)}),
        32'({out_format, out_byte, out_load, five_bit_immediate_field, base_register_field,
        dest_register_field}));
    end
  endtask
  task t_sp_adj();
    for (int i = 0; i < 2; i++) begin
      put({8'hB0, 1'(i), 7'(i * 127)}, 0);
      chk("sp", 32'({CIFD_FMT_SP_ADJ, 1'(i), 7'(i * 127)}),
        32'({out_format, out_sp_negative, stack_adjust_magnitude}));
    end
  endtask
  task t_long_bl();
    for (int i = 0; i < 2; i++) begin
      put({4'hF, 1'(i), 11'(1365 + i * 682)}, 0);
      chk("bl", 32'({CIFD_FMT_LONG_BL, 1'(i), 11'(1365 + i * 682)}),
        32'({out_format, out_second_half, branch_offset_field}));
    end
  endtask
  task t_none();
    put(16'h5A8B, 0);
    chk("none", 32'h0, 32'(out_format) | native_word);
    chk("fields", 32'h0, 32'(|{out_load, out_byte, out_sp_negative,
      out_second_half, offset_register_field, base_register_field, dest_register_field,
      five_bit_immediate_field, stack_adjust_magnitude, branch_offset_field}));
    put(16'hB180, 0);
    chk("none", 32'h0, 32'(out_format) | native_word);
    put(16'h0, 1);
    chk("idle", 32'h0, 32'(out_format) | native_word);
  endtask
  task t_reset();
    req = 1;
    word = 16'h5888;
    nrst = 0;
    @(posedge sys_clk);
    #1;
    chk("reset", 32'h0, 32'({out_valid, out_format}) | native_word);
    nrst = 1;
    put(16'h5888, 0);
    chk("reg", 32'({CIFD_FMT_REG_OFS, 5'h12, 3'h1, 3'h0}),
      32'({out_format, out_load, out_byte, offset_register_field, base_register_field,
      dest_register_field}));
    chk("native", 32'h1, 32'(native_word != 32'h0));
  endtask
  task finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    nrst = 1;
    put(16'h0, 1);
    t_reg_ofs();
    t_imm_ofs();
    t_sp_adj();
    t_long_bl();
    t_reset();
    t_none();
    finish_test();
  end
endmodule // compact_instruction_format_decoder_tb_top
`default_nettype wire
